// File: inc/ssd_pkg.sv
// package: command source codes, direction codes and carrier structs for the selector
package ssd_pkg;

  // ==========================================================
  // register layout
  localparam int SRC_W = 16;
  localparam logic [15:0] SRC_RESET = 16'h0002;
  localparam int DIR_W = 2;

  // ==========================================================
  // command source codes
  localparam logic [15:0] SRC_NONE = 16'h0000;
  localparam logic [15:0] SRC_LEVEL_RUN = 16'h0001;
  localparam logic [15:0] SRC_LEVEL_RUN_WITH_DIR = 16'h0002;
  localparam logic [15:0] SRC_PULSE_RUN_HALT = 16'h0003;
  localparam logic [15:0] SRC_PULSE_RUN_HALT_DIR = 16'h0004;
  localparam logic [15:0] SRC_PULSE_FWD_REV_HALT = 16'h0005;
  localparam logic [15:0] SRC_PANEL = 16'h0008;
  localparam logic [15:0] SRC_TWO_INPUT_FWD_REV = 16'h0009;
  localparam logic [15:0] SRC_BUS = 16'h000A;
  localparam logic [15:0] SRC_TIMER_FIRST = 16'h000B;
  localparam logic [15:0] SRC_TIMER_LAST = 16'h000E;
  localparam logic [15:0] SRC_LEVEL_RUN_INPUT_FIVE = 16'h0014;

  // ==========================================================
  // direction setting codes
  localparam logic [1:0] DIR_FORWARD = 2'h1;
  localparam logic [1:0] DIR_REVERSE = 2'h2;
  localparam logic [1:0] DIR_REQUEST = 2'h3;

  // ==========================================================
  // field positions
  localparam int BUS_RUN_BIT = 0;
  localparam int BUS_STOP_BIT = 1;
  localparam int TIMER_COUNT = 4;

  // digital inputs as one group
  typedef struct packed {
    logic five;
    logic three;
    logic two;
    logic one;
  } ssd_inputs_t;

  // panel command group
  typedef struct packed {
    logic start;
    logic stop;
    logic reverse;
  } ssd_panel_t;

endpackage : ssd_pkg

// File: rtl/ssd_edge.sv
// module: one-cycle rise and fall detector for a synchronous input
`timescale 1ns/1ns
module ssd_edge (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // level in, edges out
  input wire logic level,
  output logic rise,
  output logic fall
);

  // ==========================================================
  // previous level
  logic prev;
  logic next_prev;

  // next value of the delay stage
  always_comb
  begin
    next_prev = level;
  end

  // register; reset low so a high input at release counts as a rise
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prev <= 1'b0;
    end
    else
    begin
      prev <= next_prev;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule : ssd_edge

// File: rtl/ssd_selector.sv
// module: start/stop/direction command source selector for the first external location
//
// Contract
// - code 0 takes no commands at all
// - code 1 runs on input one level
// - permissive direction counts as forward when fixed
// - code 2 input one runs, input two direction
// - code 3 rise one starts, fall two stops
// - code 4 adds direction from input three
// - code 5 forward, reverse starts; fall three stops
// - code 8 panel gives run, stop, direction
// - code 9 inputs one and two jointly
// - code 10 bus word low bits run/stop
// - codes 11-14 run while chosen timer active
// - code 20 runs on input five level
// - reset selects code 2
// - direction 1 forward, 2 reverse, 3 request
`timescale 1ns/1ns
module ssd_selector #(
  parameter int TIMERS = ssd_pkg::TIMER_COUNT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // parameter register write port
  input wire logic source_write,
  input wire logic [15:0] source_wdata,
  output logic [15:0] location_one_command_source,
  // direction setting and location select
  input wire logic [1:0] direction_setting,
  input wire logic first_external_location,
  // command sources
  input wire ssd_pkg::ssd_inputs_t inputs,
  input wire ssd_pkg::ssd_panel_t panel,
  input wire logic [15:0] bus_control_word_one,
  input wire logic [TIMERS-1:0] timer_active,
  // requests to the drive
  output logic run_request,
  output logic reverse_request
);

  // ==========================================================
  // edge detection on the pulse inputs
  logic rise_one;
  logic rise_two;
  logic fall_two;
  logic fall_three;

  ssd_edge u_edge_one (
    .mclk(mclk),
    .rst(rst),
    .level(inputs.one),
    .rise(rise_one),
    .fall()
  );

  ssd_edge u_edge_two (
    .mclk(mclk),
    .rst(rst),
    .level(inputs.two),
    .rise(rise_two),
    .fall(fall_two)
  );

  ssd_edge u_edge_three (
    .mclk(mclk),
    .rst(rst),
    .level(inputs.three),
    .rise(),
    .fall(fall_three)
  );

  // ==========================================================
  // state
  logic [15:0] source;
  logic run;
  logic reverse;
  logic latched;
  logic latched_rev;
  logic [15:0] next_source;
  logic next_run;
  logic next_reverse;
  logic next_latched;
  logic next_latched_rev;
  logic fixed_rev;
  logic req_ok;
  logic [15:0] timer_idx;

  // fixed direction: request and forward both mean forward
  assign fixed_rev = (direction_setting == ssd_pkg::DIR_REVERSE);
  assign req_ok = (direction_setting == ssd_pkg::DIR_REQUEST);
  assign timer_idx = source - ssd_pkg::SRC_TIMER_FIRST;

  // next values; the pulse latch keeps its state so a stop stays a stop
  always_comb
  begin
    next_source = source;
    next_latched = latched;
    next_latched_rev = latched_rev;
    next_run = 1'b0;
    next_reverse = fixed_rev;
    if (source_write)
    begin
      next_source = source_wdata;
    end
    // pulse latch: a start is only honoured with the stop input held high
    case (source)
      ssd_pkg::SRC_PULSE_RUN_HALT, ssd_pkg::SRC_PULSE_RUN_HALT_DIR:
      begin
        if (!inputs.two || fall_two)
        begin
          next_latched = 1'b0;
        end
        else if (rise_one && first_external_location)
        begin
          next_latched = 1'b1;
        end
      end
      ssd_pkg::SRC_PULSE_FWD_REV_HALT:
      begin
        if (!inputs.three || fall_three)
        begin
          next_latched = 1'b0;
        end
        else if (first_external_location && (rise_one || rise_two))
        begin
          next_latched = 1'b1;
          next_latched_rev = rise_two & ~rise_one;
        end
      end
      default:
      begin
        next_latched = 1'b0;
      end
    endcase
    // output selection
    case (source)
      ssd_pkg::SRC_NONE:
      begin
        next_run = 1'b0;
      end
      ssd_pkg::SRC_LEVEL_RUN:
      begin
        next_run = inputs.one;
      end
      ssd_pkg::SRC_LEVEL_RUN_WITH_DIR:
      begin
        next_run = inputs.one;
        next_reverse = req_ok ? inputs.two : fixed_rev;
      end
      ssd_pkg::SRC_PULSE_RUN_HALT:
      begin
        next_run = next_latched;
      end
      ssd_pkg::SRC_PULSE_RUN_HALT_DIR:
      begin
        next_run = next_latched;
        next_reverse = req_ok ? inputs.three : fixed_rev;
      end
      ssd_pkg::SRC_PULSE_FWD_REV_HALT:
      begin
        next_run = next_latched;
        next_reverse = req_ok ? next_latched_rev : fixed_rev;
      end
      ssd_pkg::SRC_PANEL:
      begin
        // a panel stop overrides a simultaneous start
        next_run = run & ~panel.stop | panel.start & ~panel.stop;
        next_reverse = req_ok ? panel.reverse : fixed_rev;
      end
      ssd_pkg::SRC_TWO_INPUT_FWD_REV:
      begin
        next_run = inputs.one ^ inputs.two;
        next_reverse = req_ok ? (inputs.two & ~inputs.one) : fixed_rev;
      end
      ssd_pkg::SRC_BUS:
      begin
        // stop bit wins over run bit
        next_run = bus_control_word_one[ssd_pkg::BUS_RUN_BIT]
                   & ~bus_control_word_one[ssd_pkg::BUS_STOP_BIT];
      end
      ssd_pkg::SRC_LEVEL_RUN_INPUT_FIVE:
      begin
        next_run = inputs.five;
      end
      default:
      begin
        if (source >= ssd_pkg::SRC_TIMER_FIRST && source <= ssd_pkg::SRC_TIMER_LAST)
        begin
          next_run = timer_active[timer_idx[1:0]];
        end
      end
    endcase
    // location gate: other location owns the motor
    if (!first_external_location)
    begin
      next_run = 1'b0;
      next_reverse = reverse;
    end
  end

  // registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      source <= ssd_pkg::SRC_RESET;
      run <= 1'b0;
      reverse <= 1'b0;
      latched <= 1'b0;
      latched_rev <= 1'b0;
    end
    else
    begin
      source <= next_source;
      run <= next_run;
      reverse <= next_reverse;
      latched <= next_latched;
      latched_rev <= next_latched_rev;
    end
  end

  assign location_one_command_source = source;
  assign run_request = run;
  assign reverse_request = reverse;

endmodule : ssd_selector

// File: verif/ssd_selector_asserts.sv
// checker: port assertions for the command source selector
`timescale 1ns/1ns
module ssd_selector_asserts #(
  parameter int TIMERS = 4
) (
  // selector ports, watched only
  input wire logic mclk,
  input wire logic rst,
  input wire logic source_write,
  input wire logic [15:0] source_wdata,
  input wire logic [15:0] location_one_command_source,
  input wire logic [1:0] direction_setting,
  input wire logic first_external_location,
  input wire ssd_pkg::ssd_inputs_t inputs,
  input wire ssd_pkg::ssd_panel_t panel,
  input wire logic [15:0] bus_control_word_one,
  input wire logic [TIMERS-1:0] timer_active,
  input wire logic run_request,
  input wire logic reverse_request
);
  // ==========
  // aliases; a stored code steers the outputs from the next edge
  wire [15:0] c = location_one_command_source;
  wire on = first_external_location;
  wire run = run_request;
  wire rev = reverse_request;
  wire d3 = direction_setting == 2'h3;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_NONE: assert property (c == 16'h0 |=> !run) else $error("run with no source");
  AST_LEVEL: assert property (c == 16'h1 && on |=> run == $past(inputs.one))
    else $error("run not input one");
  AST_FWD: assert property (c == 16'h1 && on && d3 |=> !rev) else $error("not forward");
  AST_DIR: assert property (c == 16'h2 && on && d3 |=> rev == $past(inputs.two))
    else $error("dir not input two");
  AST_HALT: assert property (c == 16'h3 && on && $fell(inputs.two) |-> ##[1:2] !run)
    else $error("no halt");
  AST_PAIR: assert property (c == 16'h9 && on && inputs.one == inputs.two |=> !run)
    else $error("pair ran");
  AST_BUS: assert property (c == 16'hA && on && bus_control_word_one[1] |=> !run)
    else $error("bus stop lost");
  AST_FIVE: assert property (c == 16'h14 && on |=> run == $past(inputs.five))
    else $error("run not input five");
  AST_RESET: assert property ($fell(rst) |-> c == 16'h2) else $error("bad reset code");
  AST_REV: assert property (c == 16'h1 && on && direction_setting == 2'h2 |=> rev)
    else $error("not reverse");
  AST_OFF: assert property (!on |=> !run) else $error("run while inactive");
endmodule : ssd_selector_asserts

// File: verif/ssd_partner.sv
// partner: switches, panel, bus controller and timers feeding the selector
`timescale 1ns/1ns
module ssd_partner (
  // clock
  input wire logic mclk,
  // command sources
  output ssd_pkg::ssd_inputs_t inputs,
  output ssd_pkg::ssd_panel_t panel,
  output logic [15:0] bus_control_word_one,
  output logic [3:0] timer_active
);
  // ==========
  // sources rest low and move only on the falling edge
  initial {inputs, panel, bus_control_word_one, timer_active} = 27'h0;
  task put(input logic [3:0] i, input logic [2:0] p, input logic [15:0] b, input logic [3:0] t);
    @(negedge mclk);
    inputs = i;
    panel = p;
    bus_control_word_one = b;
    timer_active = t;
  endtask : put
  // stop input rises a cycle ahead; a start edge in the same cycle as the stop rise is also honoured
  task pulse(input logic [3:0] halt, input logic [3:0] go);
    put(halt, 3'h0, 16'h0, 4'h0);
    put(halt | go, 3'h0, 16'h0, 4'h0);
  endtask : pulse
endmodule : ssd_partner

// File: verif/ssd_selector_tb.sv
// testbench: self-checking run of the command source selector
`timescale 1ns/1ns
module ssd_selector_tb;
  // ==========
  // signals named as the selector ports
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic source_write = 1'b0;
  logic [15:0] source_wdata = 16'h0;
  logic [1:0] direction_setting = 2'h3;
  logic first_external_location = 1'b1;
  ssd_pkg::ssd_inputs_t inputs;
  ssd_pkg::ssd_panel_t panel;
  logic [15:0] bus_control_word_one;
  logic [3:0] timer_active;
  logic [15:0] location_one_command_source;
  logic run_request;
  logic reverse_request;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  ssd_partner ssd_partner_inst (.mclk, .inputs, .panel, .bus_control_word_one, .timer_active);
  ssd_selector ssd_selector_inst (.mclk, .rst, .source_write, .source_wdata,
    .location_one_command_source, .direction_setting, .first_external_location, .inputs,
    .panel, .bus_control_word_one, .timer_active, .run_request, .reverse_request);
  // ==========
  // helpers
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [15:0] v);
    @(negedge mclk);
    source_write = 1'b1;
    source_wdata = v;
    @(negedge mclk);
    source_write = 1'b0;
  endtask : wr
  // three cycles covers edge detection plus the output flop
  task cx(input logic r);
    repeat (3) @(negedge mclk);
    chk("run", {15'h0, r}, {15'h0, run_request});
  endtask : cx
  task cr(input logic r, input logic v);
    cx(r);
    chk("rev", {15'h0, v}, {15'h0, reverse_request});
  endtask : cr
  task sw(input logic [3:0] i);
    ssd_partner_inst.put(i, 3'h0, 16'h0, 4'h0);
  endtask : sw
  // ==========
  // scenarios
  task t_level;
    chk("code", 16'h2, location_one_command_source);
    wr(16'h1);
    sw(4'h1);
    cr(1'b1, 1'b0);
    direction_setting = 2'h2;
    cr(1'b1, 1'b1);
    first_external_location = 1'b0;
    cr(1'b0, 1'b1);
    first_external_location = 1'b1;
    direction_setting = 2'h3;
    wr(16'h14);
    sw(4'h8);
    cr(1'b1, 1'b0);
    wr(16'h2);
    sw(4'h3);
    cr(1'b1, 1'b1);
  endtask : t_level
  task t_pulse;
    wr(16'h3);
    sw(4'h0);
    sw(4'h1);
    cx(1'b0);
    ssd_partner_inst.pulse(4'h2, 4'h1);
    cr(1'b1, 1'b0);
    sw(4'h1);
    cx(1'b0);
    wr(16'h4);
    ssd_partner_inst.pulse(4'h2, 4'h5);
    cr(1'b1, 1'b1);
    sw(4'h4);
    cr(1'b0, 1'b1);
    wr(16'h5);
    ssd_partner_inst.pulse(4'h4, 4'h2);
    cr(1'b1, 1'b1);
    sw(4'h2);
    cx(1'b0);
    ssd_partner_inst.pulse(4'h4, 4'h1);
    cr(1'b1, 1'b0);
  endtask : t_pulse
  task t_misc;
    // stop first so that the start below is what raises run, then let run hold alone
    wr(16'h8);
    ssd_partner_inst.put(4'h0, 3'h2, 16'h0, 4'h0);
    cx(1'b0);
    ssd_partner_inst.put(4'h0, 3'h5, 16'h0, 4'h0);
    ssd_partner_inst.put(4'h0, 3'h1, 16'h0, 4'h0);
    cr(1'b1, 1'b1);
    ssd_partner_inst.put(4'h0, 3'h2, 16'h0, 4'h0);
    cx(1'b0);
    wr(16'h9);
    sw(4'h2);
    cr(1'b1, 1'b1);
    sw(4'h3);
    cx(1'b0);
    sw(4'h1);
    cr(1'b1, 1'b0);
    wr(16'hA);
    ssd_partner_inst.put(4'h0, 3'h0, 16'h3, 4'h0);
    cx(1'b0);
    ssd_partner_inst.put(4'h0, 3'h0, 16'h1, 4'h0);
    cx(1'b1);
    for (logic [15:0] k = 16'h0; k < 16'h4; k++)
    begin
      wr(16'hB + k);
      ssd_partner_inst.put(4'h0, 3'h0, 16'h0, 4'h1 << k);
      cx(1'b1);
      ssd_partner_inst.put(4'h0, 3'h0, 16'h0, ~(4'h1 << k));
      cx(1'b0);
    end
    wr(16'h0);
    ssd_partner_inst.put(4'hF, 3'h4, 16'h1, 4'hF);
    cx(1'b0);
  endtask : t_misc
  // reset in mid-run must bring back code 2 and drop run
  task t_reset;
    wr(16'h1);
    chk("code", 16'h1, location_one_command_source);
    sw(4'h1);
    cx(1'b1);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk("code", 16'h2, location_one_command_source);
    chk("run", 16'h0, {15'h0, run_request});
    cr(1'b1, 1'b0);
  endtask : t_reset
  task close_out(input int extra);
    n_fail += extra;
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // ==========
  // main sequence; a hang is cut short by the cycle ceiling
  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    t_level();
    t_pulse();
    t_misc();
    t_reset();
    close_out(0);
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
      close_out(1);
  end
endmodule : ssd_selector_tb
bind ssd_selector ssd_selector_asserts #(.TIMERS(TIMERS)) ssd_selector_asserts_inst (.mclk, .rst,
  .source_write, .source_wdata, .location_one_command_source, .direction_setting,
  .first_external_location, .inputs, .panel, .bus_control_word_one, .timer_active,
  .run_request, .reverse_request);
